/* hdl/pmmpc_pkg.sv */
// constants for the counter array mode and pwm configuration block
package pmmpc_pkg;
	localparam int NUM_MODULES = 6;
	localparam int WATCHDOG_MODULE = 5;

	// special function register pages and addresses
	localparam logic [7:0] PAGE_MAIN = 8'h00;
	localparam logic [7:0] PAGE_CONFIG = 8'h0f;
	localparam logic [7:0] ADDR_PWM_CFG = 8'hd9;
	localparam logic [5:0][7:0] ADDR_MODE = {8'hdf, 8'hde, 8'hdd, 8'hdc, 8'hdb, 8'hda};
	localparam logic [5:0][7:0] ADDR_CMP_LOW = {8'hce, 8'hfd, 8'hed, 8'heb, 8'he9, 8'hfb};
	localparam logic [5:0][7:0] ADDR_CMP_HIGH = {8'hcf, 8'hfe, 8'hee, 8'hec, 8'hea, 8'hfc};

	// pwm_cycle_configuration fields
	localparam int CFG_RELOAD_SEL = 7;
	localparam int CFG_COV_IRQ_EN = 6;
	localparam int CFG_COV_FLAG = 5;
	localparam int CFG_CLSEL_MSB = 1;
	localparam int CFG_CLSEL_LSB = 0;
	localparam logic [2:0] CFG_UNUSED_READ = 3'h0;

	// moduleN_mode_control fields
	localparam int MODE_WIDE = 7;
	localparam int MODE_CMP = 6;
	localparam int MODE_RISE = 5;
	localparam int MODE_FALL = 4;
	localparam int MODE_MATCH = 3;
	localparam int MODE_TOGGLE = 2;
	localparam int MODE_PWM = 1;
	localparam int MODE_IRQ = 0;

	// reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [1:0] CLSEL_RESET = 2'h0;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// cycle length codes and the counter bits each one spans
	localparam logic [1:0] CLSEL_8 = 2'h0;
	localparam logic [1:0] CLSEL_9 = 2'h1;
	localparam logic [1:0] CLSEL_10 = 2'h2;
	localparam logic [1:0] CLSEL_11 = 2'h3;
	localparam logic [15:0] MASK_8 = 16'h00ff;
	localparam logic [15:0] MASK_9 = 16'h01ff;
	localparam logic [15:0] MASK_10 = 16'h03ff;
	localparam logic [15:0] MASK_11 = 16'h07ff;
	localparam logic [15:0] COUNTER_ZERO = 16'h0000;
endpackage

/* hdl/pmmpc_pin_sync.sv */
// three-stage synchroniser with edge pulses for one module pin
`timescale 1ns/100ps
module pmmpc_pin_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// raw pin
	input wire logic pin_in,
	// filtered level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	logic stage1;
	logic stage2;
	logic stage3;

	// idle level is high so a quiet pin gives no edge after reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stage1 <= 1'b1;
			stage2 <= 1'b1;
			stage3 <= 1'b1;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a change counts only once the second and third stages agree
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			level <= 1'b1;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			rise <= 1'b0;
			fall <= 1'b0;
			if (stage2 == stage3 && stage3 != level) begin
				level <= stage3;
				rise <= stage3;
				fall <= ~stage3;
			end
		end
	end
endmodule

/* hdl/pmmpc_channel.sv */
// one capture/compare module: match, capture, toggle, pwm and frequency output
`timescale 1ns/100ps
module pmmpc_channel (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// configuration
	input wire logic [7:0] mode,
	input wire logic [15:0] cmp_value,
	input wire logic [15:0] cycle_mask,
	// shared counter
	input wire logic [15:0] main_counter,
	input wire logic counter_tick,
	// synchronised pin edges
	input wire logic pin_rise,
	input wire logic pin_fall,
	// events and pin drive
	output logic match_event,
	output logic capture_event,
	output logic freq_advance,
	output logic pin_level,
	output logic pin_drive
);
	logic full_match;
	logic cycle_match;
	logic low_match;
	logic cycle_wrap;
	logic wide_wrap;
	logic freq_mode;

	assign full_match = main_counter == cmp_value;
	assign cycle_match = (main_counter & cycle_mask) == (cmp_value & cycle_mask);
	assign low_match = main_counter[7:0] == cmp_value[7:0];
	assign cycle_wrap = (main_counter & cycle_mask) == pmmpc_pkg::COUNTER_ZERO;
	assign wide_wrap = main_counter == pmmpc_pkg::COUNTER_ZERO;
	assign freq_mode = mode[pmmpc_pkg::MODE_TOGGLE] & mode[pmmpc_pkg::MODE_PWM]; // R15

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			match_event <= 1'b0;
			capture_event <= 1'b0;
			freq_advance <= 1'b0;
		end else begin
			match_event <= counter_tick & mode[pmmpc_pkg::MODE_CMP]
				& mode[pmmpc_pkg::MODE_MATCH] & full_match; // R10 R13
			capture_event <= (mode[pmmpc_pkg::MODE_RISE] & pin_rise) // R11
				| (mode[pmmpc_pkg::MODE_FALL] & pin_fall); // R12
			freq_advance <= counter_tick & mode[pmmpc_pkg::MODE_CMP] & freq_mode & low_match;
		end
	end

	// pwm goes low on match and high again when its cycle wraps
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pin_level <= 1'b1;
		end else if (counter_tick && mode[pmmpc_pkg::MODE_CMP]) begin // R10
			if (freq_mode) begin
				if (low_match) begin
					pin_level <= ~pin_level; // R15
				end
			end else if (mode[pmmpc_pkg::MODE_PWM]) begin // R16
				if (mode[pmmpc_pkg::MODE_WIDE]) begin // R09
					if (full_match) begin
						pin_level <= 1'b0;
					end else if (wide_wrap) begin
						pin_level <= 1'b1;
					end
				end else if (cycle_match) begin // R08
					pin_level <= 1'b0;
				end else if (cycle_wrap) begin
					pin_level <= 1'b1;
				end
			end else if (mode[pmmpc_pkg::MODE_TOGGLE] && full_match) begin
				pin_level <= ~pin_level; // R14
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pin_drive <= 1'b0;
		end else begin
			pin_drive <= mode[pmmpc_pkg::MODE_CMP]
				& (mode[pmmpc_pkg::MODE_TOGGLE] | mode[pmmpc_pkg::MODE_PWM]);
		end
	end
endmodule

/* hdl/pmmpc_top.sv */
// counter array mode registers, shared pwm configuration and six modules
//
// Behaviour
// R01: reload select steers compare byte accesses
// R02: reload values used only in 9-11 bit pwm
// R03: overflow flag with enable raises shared interrupt
// R04: overflow flag set at selected counter bit
// R05: flag set by hardware or software, software clears
// R06: config bits 4 to 2 read zero
// R07: cycle codes 00, 01, 10 give 8, 9, 10
// R08: cycle length shared by narrow pwm modules
// R09: wide pwm bit picks 16-bit pwm
// R10: comparator functions only with comparator enable
// R11: rising pin edge captures counter when enabled
// R12: falling pin edge captures counter when enabled
// R13: counter match sets module flag when enabled
// R14: counter match toggles pin when enabled
// R15: toggle plus pwm gives frequency output
// R16: pwm enable drives modulated waveform on pin
// R17: module interrupt enable gates module flag
// R18: watchdog enable locks module 5 mode register
// R19: watchdog enable dedicates module 5 to watchdog
// R20: module flag set by hardware, cleared by software
// R21: compare low byte write clears comparator enable
// R22: cycle code 11 gives 11-bit cycle
`timescale 1ns/100ps
module pmmpc_top (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// special function register port
	input wire logic [7:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// shared main counter and watchdog state
	input wire logic [15:0] main_counter,
	input wire logic counter_tick,
	input wire logic watchdog_enable,
	// module event flags
	input wire logic [5:0] flag_clear,
	output logic [5:0] module_event_flag,
	output logic cycle_overflow_flag,
	// module pins
	input wire logic [5:0] module_io_pin_in,
	output logic [5:0] module_io_pin_out,
	output logic [5:0] module_io_pin_oe,
	// shared interrupt
	output logic counter_array_irq
);
	localparam int N = pmmpc_pkg::NUM_MODULES;

	// pwm_cycle_configuration fields
	logic reload_register_select;
	logic cycle_overflow_irq_enable;
	logic [1:0] cycle_length_select;
	logic [15:0] cycle_mask;

	// per-module state
	logic [7:0] mode_reg [N];
	logic [7:0] mode_eff [N];
	logic [15:0] cmp_value [N];
	logic [15:0] reload_value [N];

	// decodes and events
	logic sel_cfg;
	logic wr_cfg;
	logic cov_event;
	logic [N-1:0] hit_mode;
	logic [N-1:0] hit_low;
	logic [N-1:0] hit_high;
	logic [N-1:0] wr_mode;
	logic [N-1:0] wr_low;
	logic [N-1:0] wr_high;
	logic [N-1:0] pin_rise;
	logic [N-1:0] pin_fall;
	logic [N-1:0] match_event;
	logic [N-1:0] capture_event;
	logic [N-1:0] freq_advance;
	logic [N-1:0] narrow_pwm;
	logic [N-1:0] irq_enable;
	logic [7:0] next_rdata;
	logic [N-1:0] mode_lock;
	logic [N-1:0] cycle_reload;
	logic [7:0] cfg_word;
	logic [7:0] read_word [N];

	assign sel_cfg = sfr_page == pmmpc_pkg::PAGE_CONFIG && sfr_addr == pmmpc_pkg::ADDR_PWM_CFG;
	assign wr_cfg = sfr_wr & sel_cfg;

	// overflow of the selected counter bit shows as those low bits wrapping to zero
	always_comb begin
		unique case (cycle_length_select)
			pmmpc_pkg::CLSEL_8: cycle_mask = pmmpc_pkg::MASK_8; // R07
			pmmpc_pkg::CLSEL_9: cycle_mask = pmmpc_pkg::MASK_9; // R07
			pmmpc_pkg::CLSEL_10: cycle_mask = pmmpc_pkg::MASK_10; // R07
			pmmpc_pkg::CLSEL_11: cycle_mask = pmmpc_pkg::MASK_11; // R22
		endcase
	end

	assign cov_event = counter_tick && (main_counter & cycle_mask) == pmmpc_pkg::COUNTER_ZERO; // R04

	// configuration fields; writes to bits 4 to 2 land nowhere
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reload_register_select <= 1'b0;
		end else if (wr_cfg) begin // R06
			reload_register_select <= sfr_wdata[pmmpc_pkg::CFG_RELOAD_SEL]; // R01
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cycle_overflow_irq_enable <= 1'b0;
		end else if (wr_cfg) begin
			cycle_overflow_irq_enable <= sfr_wdata[pmmpc_pkg::CFG_COV_IRQ_EN]; // R03
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cycle_length_select <= pmmpc_pkg::CLSEL_RESET;
		end else if (wr_cfg) begin
			cycle_length_select <= sfr_wdata[pmmpc_pkg::CFG_CLSEL_MSB:pmmpc_pkg::CFG_CLSEL_LSB];
		end
	end

	// an overflow in the same cycle as a clearing write keeps the flag set
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cycle_overflow_flag <= 1'b0;
		end else if (cov_event) begin
			cycle_overflow_flag <= 1'b1; // R04 R05
		end else if (wr_cfg) begin
			cycle_overflow_flag <= sfr_wdata[pmmpc_pkg::CFG_COV_FLAG]; // R05
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_mod
			assign hit_mode[i] = sfr_page == pmmpc_pkg::PAGE_MAIN
				&& sfr_addr == pmmpc_pkg::ADDR_MODE[i];
			assign hit_low[i] = sfr_page == pmmpc_pkg::PAGE_MAIN
				&& sfr_addr == pmmpc_pkg::ADDR_CMP_LOW[i];
			assign hit_high[i] = sfr_page == pmmpc_pkg::PAGE_MAIN
				&& sfr_addr == pmmpc_pkg::ADDR_CMP_HIGH[i];
			assign wr_low[i] = sfr_wr & hit_low[i];
			assign wr_high[i] = sfr_wr & hit_high[i];
			if (i == pmmpc_pkg::WATCHDOG_MODULE) begin : g_wd
				assign mode_lock[i] = watchdog_enable; // R18
				// the watchdog owns this module, so its own pin functions stand idle
				assign mode_eff[i] = watchdog_enable ? pmmpc_pkg::MODE_RESET : mode_reg[i]; // R19
			end else begin : g_plain
				assign mode_lock[i] = 1'b0;
				assign mode_eff[i] = mode_reg[i];
			end
			// a locked mode register also keeps its enable through a low byte write
			assign wr_mode[i] = sfr_wr & hit_mode[i] & ~mode_lock[i]; // R18
			assign narrow_pwm[i] = mode_eff[i][pmmpc_pkg::MODE_CMP]
				& mode_eff[i][pmmpc_pkg::MODE_PWM]
				& ~mode_eff[i][pmmpc_pkg::MODE_TOGGLE]
				& ~mode_eff[i][pmmpc_pkg::MODE_WIDE]; // R08 R09
			assign irq_enable[i] = mode_eff[i][pmmpc_pkg::MODE_IRQ];
			assign cycle_reload[i] = cov_event & narrow_pwm[i]; // R02

			// each module answers for its own three addresses only
			always_comb begin
				read_word[i] = pmmpc_pkg::READ_UNMAPPED;
				if (hit_mode[i]) begin
					read_word[i] = mode_reg[i];
				end else if (hit_low[i]) begin
					read_word[i] = reload_register_select ? reload_value[i][7:0]
						: cmp_value[i][7:0]; // R01
				end else if (hit_high[i]) begin
					read_word[i] = reload_register_select ? reload_value[i][15:8]
						: cmp_value[i][15:8]; // R01
				end
			end

			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					mode_reg[i] <= pmmpc_pkg::MODE_RESET;
				end else if (wr_mode[i]) begin
					mode_reg[i] <= sfr_wdata;
				end else if (wr_low[i] && !mode_lock[i]) begin
					mode_reg[i][pmmpc_pkg::MODE_CMP] <= 1'b0; // R21
				end
			end

			// compare value: capture first, then software, then hardware reloads
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					cmp_value[i] <= pmmpc_pkg::CMP_RESET;
				end else if (capture_event[i]) begin
					cmp_value[i] <= main_counter; // R11 R12
				end else if (wr_low[i] && !reload_register_select) begin
					cmp_value[i][7:0] <= sfr_wdata; // R01
				end else if (wr_high[i] && !reload_register_select) begin
					cmp_value[i][15:8] <= sfr_wdata; // R01
				end else if (freq_advance[i]) begin
					cmp_value[i][7:0] <= cmp_value[i][7:0] + cmp_value[i][15:8];
				end else if (cycle_reload[i]) begin
					if (cycle_length_select == pmmpc_pkg::CLSEL_8) begin
						cmp_value[i][7:0] <= cmp_value[i][15:8];
					end else begin
						cmp_value[i] <= reload_value[i]; // R02
					end
				end
			end

			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					reload_value[i] <= pmmpc_pkg::CMP_RESET;
				end else if (wr_low[i] && reload_register_select) begin
					reload_value[i][7:0] <= sfr_wdata; // R01
				end else if (wr_high[i] && reload_register_select) begin
					reload_value[i][15:8] <= sfr_wdata; // R01
				end
			end

			// set wins over a clear in the same cycle
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					module_event_flag[i] <= 1'b0;
				end else if (match_event[i] || capture_event[i]) begin
					module_event_flag[i] <= 1'b1; // R13 R20
				end else if (flag_clear[i]) begin
					module_event_flag[i] <= 1'b0; // R20
				end
			end

			pmmpc_pin_sync u_sync (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.pin_in(module_io_pin_in[i]),
				.level(),
				.rise(pin_rise[i]),
				.fall(pin_fall[i])
			);

			pmmpc_channel u_chan (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.mode(mode_eff[i]),
				.cmp_value(cmp_value[i]),
				.cycle_mask(cycle_mask),
				.main_counter(main_counter),
				.counter_tick(counter_tick),
				.pin_rise(pin_rise[i]),
				.pin_fall(pin_fall[i]),
				.match_event(match_event[i]),
				.capture_event(capture_event[i]),
				.freq_advance(freq_advance[i]),
				.pin_level(module_io_pin_out[i]),
				.pin_drive(module_io_pin_oe[i])
			);
		end
	endgenerate

	assign cfg_word = {reload_register_select, cycle_overflow_irq_enable, cycle_overflow_flag,
		pmmpc_pkg::CFG_UNUSED_READ, cycle_length_select}; // R06

	// read data is registered, so it appears the cycle after the read strobe
	always_comb begin
		next_rdata = sel_cfg ? cfg_word : pmmpc_pkg::READ_UNMAPPED;
		// decodes are exclusive, so or-ing the module words yields the one that was hit
		for (int k = 0; k < N; k++) begin
			next_rdata = next_rdata | read_word[k];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sfr_rdata <= pmmpc_pkg::READ_UNMAPPED;
		end else if (sfr_rd) begin
			sfr_rdata <= next_rdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			counter_array_irq <= 1'b0;
		end else begin
			counter_array_irq <= (cycle_overflow_flag & cycle_overflow_irq_enable) // R03
				| (|(module_event_flag & irq_enable)); // R17
		end
	end
endmodule

/* verification/pmmpc_pin_model.sv */
// far-side model of the six module pins
`timescale 1ns/100ps
module pmmpc_pin_model (
	// level the outside world puts on pins the module leaves free
	input wire logic [5:0] drive_level,
	// module side of the pins
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	output logic [5:0] pin_in
);
	// a driven pin reads back the module's own level, so capture also sees the module's own edges
	assign pin_in = (pin_out & pin_oe) | (drive_level & ~pin_oe);
endmodule

/* verification/pmmpc_top_checker.sv */
// port-level assertions for the counter array configuration block
`timescale 1ns/100ps
module pmmpc_top_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// counter, flags and pins
	input wire logic watchdog_enable,
	input wire logic [5:0] flag_clear,
	input wire logic [5:0] module_event_flag,
	input wire logic cycle_overflow_flag,
	input wire logic [5:0] module_io_pin_oe,
	input wire logic counter_tick,
	input wire logic [15:0] main_counter,
	input wire logic counter_array_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic cfg_sel;
	assign cfg_sel = sfr_page == pmmpc_pkg::PAGE_CONFIG && sfr_addr == pmmpc_pkg::ADDR_PWM_CFG;
	AST_IRQ_QUIET: assert property (!cycle_overflow_flag && module_event_flag == 6'h00
		|=> !counter_array_irq) else $error("irq without any flag");
	AST_CFG_ZERO: assert property (sfr_rd && cfg_sel |=> sfr_rdata[4:2] == 3'h0)
		else $error("unused config bits read nonzero");
	AST_COV_STICKY: assert property (cycle_overflow_flag && !(sfr_wr && cfg_sel && !sfr_wdata[5])
		|=> cycle_overflow_flag) else $error("overflow flag lost without clear");
	AST_FLAG_STICKY: assert property (1'b1 |=>
		($past(module_event_flag) & ~$past(flag_clear) & ~module_event_flag) == 6'h00)
		else $error("module flag lost without clear");
	AST_COV_CAUSE: assert property ($rose(cycle_overflow_flag) |-> $past(sfr_wr) ||
		($past(counter_tick) && $past(main_counter[7:0]) == 8'h00))
		else $error("overflow flag set without wrap");
	AST_WD_IDLE: assert property (watchdog_enable [*3] |-> !module_io_pin_oe[5])
		else $error("watchdog module drives its pin");
	AST_IRQ_CAUSE: assert property ($rose(counter_array_irq) |->
		$past(cycle_overflow_flag) || $past(module_event_flag) != 6'h00)
		else $error("irq rose without a flag");
	AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data changed without read");
endmodule
bind pmmpc_top pmmpc_top_checker u_chk (.mclk(mclk), .sys_rst(sys_rst), .sfr_page(sfr_page),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .watchdog_enable(watchdog_enable), .flag_clear(flag_clear),
	.module_event_flag(module_event_flag), .cycle_overflow_flag(cycle_overflow_flag),
	.module_io_pin_oe(module_io_pin_oe), .counter_tick(counter_tick),
	.main_counter(main_counter), .counter_array_irq(counter_array_irq));

/* verification/tb_pmmpc_top.sv */
// self-checking bench for the counter array configuration block
`timescale 1ns/100ps
module tb_pmmpc_top;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic counter_tick = 1'b0;
	logic watchdog_enable = 1'b0;
	logic [7:0] sfr_page = 8'h00;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [15:0] main_counter = 16'h0000;
	logic [5:0] flag_clear = 6'h00;
	logic [5:0] drive_level = 6'h3f;
	logic [5:0] flg;
	logic [5:0] pin_in;
	logic [5:0] pin_out;
	logic [5:0] pin_oe;
	logic cov;
	logic irq;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;
	localparam logic [7:0] P0 = pmmpc_pkg::PAGE_MAIN;
	localparam logic [7:0] PC = pmmpc_pkg::PAGE_CONFIG;
	localparam logic [7:0] CFG = pmmpc_pkg::ADDR_PWM_CFG;

	initial begin
		forever #10 mclk = ~mclk;
	end

	pmmpc_top dut (.mclk(mclk), .sys_rst(sys_rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.main_counter(main_counter), .counter_tick(counter_tick),
		.watchdog_enable(watchdog_enable), .flag_clear(flag_clear), .module_event_flag(flg),
		.cycle_overflow_flag(cov), .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
		.module_io_pin_oe(pin_oe), .counter_array_irq(irq));
	pmmpc_pin_model pins (.drive_level(drive_level), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_in(pin_in));

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		// the whole sequence needs under two thousand cycles
		if (cycles == 5000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_page = p;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		sfr_page = p;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge mclk);
		sfr_rd = 1'b0;
		chk(sfr_rdata, e);
	endtask

	task automatic wm(input int n, input logic [7:0] d);
		wr(P0, pmmpc_pkg::ADDR_MODE[n], d);
	endtask

	// low byte first: the low write also clears the comparator enable, the high write does not
	task automatic wc(input int n, input logic [15:0] v);
		wr(P0, pmmpc_pkg::ADDR_CMP_LOW[n], v[7:0]);
		wr(P0, pmmpc_pkg::ADDR_CMP_HIGH[n], v[15:8]);
	endtask

	// one counter advance, then settle time for flag, pin and irq stages
	task automatic tk(input logic [15:0] v);
		@(negedge mclk);
		main_counter = v;
		counter_tick = 1'b1;
		@(negedge mclk);
		counter_tick = 1'b0;
		cyc(3);
	endtask

	task automatic clr(input logic [5:0] m);
		@(negedge mclk);
		flag_clear = m;
		@(negedge mclk);
		flag_clear = 6'h00;
	endtask

	task automatic t_regs();
		rd(PC, CFG, 8'h00);
		for (int n = 0; n < 6; n++) begin
			rd(P0, pmmpc_pkg::ADDR_MODE[n], 8'h00);
		end
		rd(P0, 8'h80, 8'h00);
		wr(PC, CFG, 8'hff);
		rd(PC, CFG, 8'he3);
		wr(PC, CFG, 8'h00);
		rd(PC, CFG, 8'h00);
		wm(0, 8'hbd);
		rd(P0, pmmpc_pkg::ADDR_MODE[0], 8'hbd);
		wm(0, 8'h48);
		wc(0, 16'h0000);
		rd(P0, pmmpc_pkg::ADDR_MODE[0], 8'h08);
		wm(0, 8'h00);
	endtask

	task automatic t_reload();
		wr(P0, pmmpc_pkg::ADDR_CMP_LOW[1], 8'h11);
		wr(PC, CFG, 8'h80);
		wr(P0, pmmpc_pkg::ADDR_CMP_LOW[1], 8'h22);
		rd(P0, pmmpc_pkg::ADDR_CMP_LOW[1], 8'h22);
		wr(PC, CFG, 8'h00);
		rd(P0, pmmpc_pkg::ADDR_CMP_LOW[1], 8'h11);
	endtask

	task automatic t_cov();
		for (int c = 0; c < 4; c++) begin
			wr(PC, CFG, 8'h40 | 8'(c));
			tk(16'h0080 << c);
			chk(cov, 1'b0);
			tk(16'h0100 << c);
			chk(cov, 1'b1);
			chk(irq, 1'b1);
			wr(PC, CFG, 8'(c));
			cyc(2);
			chk(cov, 1'b0);
			chk(irq, 1'b0);
		end
		wr(PC, CFG, 8'h00);
		tk(16'h0100);
		chk(cov, 1'b1);
		chk(irq, 1'b0);
		wr(PC, CFG, 8'h00);
	endtask

	// 9-bit pwm takes its compare value from the reload register at each wrap
	task automatic t_autoload();
		wr(PC, CFG, 8'h81);
		wc(0, 16'h0040);
		wr(PC, CFG, 8'h01);
		wc(0, 16'h0155);
		wm(0, 8'h42);
		tk(16'h0155);
		chk(pin_out[0], 1'b0);
		tk(16'h0200);
		chk(pin_out[0], 1'b1);
		rd(P0, pmmpc_pkg::ADDR_CMP_LOW[0], 8'h40);
		tk(16'h0240);
		chk(pin_out[0], 1'b0);
		wc(0, 16'h0155);
		wm(0, 8'h48);
		tk(16'h0400);
		rd(P0, pmmpc_pkg::ADDR_CMP_LOW[0], 8'h55);
		wm(0, 8'h00);
		wr(PC, CFG, 8'h00);
	endtask

	// frequency output toggles on a low byte match, then steps low by high
	task automatic t_freq();
		wc(3, 16'h2010);
		wm(3, 8'h46);
		tk(16'h0010);
		chk(pin_out[3], 1'b0);
		tk(16'h0010);
		chk(pin_out[3], 1'b0);
		tk(16'h0030);
		chk(pin_out[3], 1'b1);
		wm(3, 8'h00);
	endtask

	task automatic t_match();
		wc(2, 16'h1234);
		wm(2, 8'h49);
		tk(16'h1233);
		chk(flg[2], 1'b0);
		tk(16'h1234);
		chk(flg[2], 1'b1);
		chk(irq, 1'b1);
		clr(6'h04);
		cyc(2);
		chk(flg[2], 1'b0);
		chk(irq, 1'b0);
		wm(2, 8'h08);
		tk(16'h1234);
		chk(flg[2], 1'b0);
		wm(2, 8'h48);
		tk(16'h1234);
		chk(flg[2], 1'b1);
		chk(irq, 1'b0);
		clr(6'h04);
		wm(2, 8'h00);
	endtask

	task automatic t_pins();
		wc(3, 16'h0050);
		wm(3, 8'h44);
		tk(16'h0050);
		chk({pin_oe[3], pin_out[3]}, 2'b10);
		tk(16'h0050);
		chk(pin_out[3], 1'b1);
		wm(3, 8'h00);
		wc(4, 16'h0080);
		wm(4, 8'h42);
		tk(16'h0080);
		chk(pin_out[4], 1'b0);
		tk(16'h0100);
		chk(pin_out[4], 1'b1);
		wc(4, 16'h0080);
		wm(4, 8'hc2);
		tk(16'h0080);
		chk(pin_out[4], 1'b0);
		tk(16'h0100);
		chk(pin_out[4], 1'b0);
		tk(16'h0000);
		chk(pin_out[4], 1'b1);
		wm(4, 8'h00);
	endtask

	task automatic t_capture();
		wm(1, 8'h20);
		@(negedge mclk);
		main_counter = 16'h0abc;
		drive_level[1] = 1'b0;
		cyc(8);
		chk(flg[1], 1'b0);
		drive_level[1] = 1'b1;
		cyc(8);
		chk(flg[1], 1'b1);
		rd(P0, pmmpc_pkg::ADDR_CMP_LOW[1], 8'hbc);
		clr(6'h02);
		wm(1, 8'h10);
		main_counter = 16'h0def;
		drive_level[1] = 1'b0;
		cyc(8);
		chk(flg[1], 1'b1);
		rd(P0, pmmpc_pkg::ADDR_CMP_HIGH[1], 8'h0d);
		clr(6'h02);
	endtask

	// module 5 drives its pin first, so the watchdog taking it over is visible
	task automatic t_wdog();
		wm(5, 8'h42);
		cyc(2);
		chk(pin_oe[5], 1'b1);
		watchdog_enable = 1'b1;
		wm(5, 8'h00);
		rd(P0, pmmpc_pkg::ADDR_MODE[5], 8'h42);
		cyc(2);
		chk(pin_oe[5], 1'b0);
		watchdog_enable = 1'b0;
		wm(5, 8'h40);
		rd(P0, pmmpc_pkg::ADDR_MODE[5], 8'h40);
		wm(5, 8'h00);
	endtask

	initial begin
		cyc(3);
		sys_rst = 1'b0;
		t_regs();
		$display("registers done");
		t_reload();
		$display("reload select done");
		t_cov();
		$display("cycle overflow done");
		t_autoload();
		$display("auto-reload done");
		t_match();
		$display("match done");
		t_pins();
		$display("toggle and pwm done");
		t_freq();
		$display("frequency output done");
		t_capture();
		$display("capture done");
		t_wdog();
		$display("watchdog lock done");
		finish_test();
	end
endmodule
